// *** tal_channel.sv ***
// Per-channel result hold, offset correction and trip comparators
`timescale 1ns/1ps
module tal_channel
    import tal_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Measurement side
    input wire logic i_conv_done,
    input wire logic [9:0] i_raw,
    input wire logic i_fault,
    input wire logic signed [9:0] i_offset,
    // Limits
    input wire logic signed [9:0] i_high,
    input wire logic signed [9:0] i_low,
    input wire logic signed [9:0] i_trip,
    input wire logic [7:0] i_hyst,
    // Results
    output logic signed [9:0] o_temp,
    output logic o_high,
    output logic o_low,
    output logic o_trip,
    output logic o_trip2
);
    logic signed [9:0] temp_q, temp_d;
    logic trip_q, trip_d, trip2_q, trip2_d;
    logic signed [10:0] trip_rel, high_rel;

    // Release points: limit minus hysteresis, one extra bit for wrap
    always_comb begin
        trip_rel = 11'(i_trip) - 11'(signed'({1'b0, i_hyst}));
        high_rel = 11'(i_high) - 11'(signed'({1'b0, i_hyst}));
        temp_d = temp_q;
        // Faulty data never overwrites the last good value (see R5)
        if (i_conv_done && !i_fault) begin
            temp_d = signed'(i_raw) + i_offset; // see R14
        end
        trip_d = trip_q;
        if (temp_q > i_trip) begin
            trip_d = 1'b1;                      // see R9
        end else if (11'(temp_q) <= trip_rel) begin
            trip_d = 1'b0;                      // see R10
        end
        trip2_d = trip2_q;
        if (temp_q > i_high) begin
            trip2_d = 1'b1;                     // see R13
        end else if (11'(temp_q) <= high_rel) begin
            trip2_d = 1'b0;                     // see R13
        end
    end

    // Register stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            temp_q <= '0;
            trip_q <= 1'b0;
            trip2_q <= 1'b0;
        end else begin
            temp_q <= temp_d;
            trip_q <= trip_d;
            trip2_q <= trip2_d;
        end
    end

    // Limit compares act on stored value, so they work in standby too
    assign o_temp = temp_q;
    assign o_high = temp_q > i_high;   // see R6
    assign o_low = temp_q <= i_low;    // see R6
    assign o_trip = trip_q;
    assign o_trip2 = trip2_q;
endmodule // tal_channel

// *** tal_host_model.sv ***
// Host model: alert response and status reads toward the alarm block
`timescale 1ns/1ps
module tal_host_model (
    // Clock
    input wire logic i_clk,
    // Status data from the block
    input wire logic [7:0] i_rd_data,
    // Requests to the block
    output logic o_ara_served,
    output logic o_rd_en,
    output logic [7:0] o_rd_addr
);
    // Idle bus, address parked on a value that is never mapped
    initial begin
        o_ara_served = 1'b0;
        o_rd_en = 1'b0;
        o_rd_addr = 8'hFF;
    end
    // Alert response answered; the pin still waits on a status read
    task automatic ara();
        @(posedge i_clk) o_ara_served <= 1'b1;
        @(posedge i_clk) o_ara_served <= 1'b0;
    endtask
    // Status read; data stands one cycle only, so grab it at once
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk) o_rd_en <= 1'b1;
        o_rd_addr <= a;
        @(posedge i_clk) o_rd_en <= 1'b0;
        o_rd_addr <= ~a; // Stale address must not look valid
        #1 d = i_rd_data;
    endtask
endmodule // tal_host_model

// *** tal_pkg.sv ***
// Package: constants for the temperature alarm and fault logic
package tal_pkg;
    // ------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] TAL_ADDR_PRIMARY_STATUS = 8'h02;
    localparam logic [7:0] TAL_ADDR_SECONDARY_STATUS = 8'h23;
    localparam int TAL_BIT_OPEN = 2;
    localparam int TAL_BIT_LOW = 3;
    localparam int TAL_BIT_HIGH = 4;
    localparam int TAL_BIT_TRIP = 1;
    localparam int TAL_CFG_MASK_ALL = 7;
    localparam int TAL_CFG_MASK_R1 = 1;
    localparam int TAL_CFG_MASK_R2 = 0;
    localparam int TAL_CONSEC_MASK_LOCAL = 5;
    // ------------------------------------------------------------
    // Reset values and channel count
    // ------------------------------------------------------------
    localparam logic [7:0] TAL_TRIP_DEFAULT = 8'h55;   // 85 degrees
    localparam logic [7:0] TAL_HYST_DEFAULT = 8'h0A;   // 10 degrees
    localparam int TAL_NCH = 3;
    localparam int TAL_CH_LOCAL = 0;
    localparam int TAL_CH_R1 = 1;
    localparam int TAL_CH_R2 = 2;
    // Alert pin state machine
    typedef enum logic [1:0] {
        TAL_AL_IDLE = 2'b00,
        TAL_AL_ASSERT = 2'b01,
        TAL_AL_SERVED = 2'b11
    } tal_alert_st_t;
endpackage

// *** tal_top.sv ***
// Top: alarm, fail-safe trip and open-fault status logic
// Function
// R1: Open comparator sampled only at conversion start.
// R2: Remote one open fault sets bit 2 of status at 0x02.
// R3: Remote two open fault sets bit 2 of status at 0x23.
// R4: Alarm mode: open fault flags drive alarm output low.
// R5: Faulty remote conversions leave last good result in place.
// R6: Alarm when above high limit or at or below low limit.
// R7: Alarm maskable; fail-safe trip has no mask.
// R8: Alarm released after alert response, cleared condition, cleared status.
// R9: Trip asserts when any channel exceeds its trip limit.
// R10: Trip releases at limit minus shared hysteresis.
// R11: Trip limits reset to 85 degrees.
// R12: Hysteresis resets to 10, reprogrammable.
// R13: Second trip mode: asserts above high limits, unmaskable, hysteresis.
// R14: Calibration offset added to each measurement.
// R15: Host should program trip limits at or above high limits.
// R16: Mask bits: local, remote one, remote two, all.
// R17: Newly written limits in standby still raise alarms.
// R18: Limit status bits stick until the status register is read.
`timescale 1ns/1ps
module tal_top
    import tal_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Conversion front end: one shared start; done, open bit and ten raw bits per channel
    input wire logic i_conv_start,
    input wire logic [TAL_NCH-1:0] i_conv_done,
    input wire logic [TAL_NCH-1:0] i_open_cmp,
    input wire logic [29:0] i_raw,
    // Programmed values; offset and limit fields ten bits per channel
    input wire logic [29:0] i_offset,
    input wire logic [29:0] i_high,
    input wire logic [29:0] i_low,
    input wire logic i_trip_wr,
    input wire logic [29:0] i_trip,
    input wire logic i_hyst_wr,
    input wire logic [7:0] i_hyst,
    input wire logic [7:0] i_cfg,
    input wire logic [7:0] i_consec,
    input wire logic i_pin_is_trip2,
    // Status read and alert response
    input wire logic i_rd_en,
    input wire logic [7:0] i_rd_addr,
    input wire logic i_ara_served,
    // Outputs
    output logic [7:0] o_rd_data,
    output logic o_alarm_n,
    output logic o_failsafe_trip_n,
    output logic [29:0] o_temp
);
    // ------------------------------------------------------------
    // Programmable trip limits and hysteresis
    // ------------------------------------------------------------
    logic [29:0] trip_q, trip_d;
    logic [7:0] hyst_q, hyst_d;
    logic [TAL_NCH-1:0] open_q, open_d, hi_q, hi_d, lo_q, lo_d;
    logic [TAL_NCH-1:0] hi_now, lo_now, trip_now, trip2_now;
    logic [TAL_NCH-1:0] mask;
    logic [7:0] rd_d, rd_q;
    logic alarm_n_q, alarm_n_d, fs_n_q, fs_n_d;
    logic rd_p, rd_s, cause;
    tal_alert_st_t st_q, st_d;

    function automatic logic [9:0] fld(input logic [29:0] v, input int c);
        fld = v[c*10 +: 10];
    endfunction

    // Channel datapaths
    for (genvar c = 0; c < TAL_NCH; c++) begin : g_ch
        tal_channel u_ch (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_conv_done(i_conv_done[c]),
            .i_raw(fld(i_raw, c)),
            .i_fault(open_q[c]),
            .i_offset(signed'(fld(i_offset, c))),
            .i_high(signed'(fld(i_high, c))),
            .i_low(signed'(fld(i_low, c))),
            .i_trip(signed'(fld(trip_q, c))),
            .i_hyst(hyst_q),
            .o_temp(o_temp[c*10 +: 10]),
            .o_high(hi_now[c]),
            .o_low(lo_now[c]),
            .o_trip(trip_now[c]),
            .o_trip2(trip2_now[c])
        );
    end

    // Mask per source plus global mask (see R16)
    always_comb begin
        mask[TAL_CH_LOCAL] = i_consec[TAL_CONSEC_MASK_LOCAL];
        mask[TAL_CH_R1] = i_cfg[TAL_CFG_MASK_R1];
        mask[TAL_CH_R2] = i_cfg[TAL_CFG_MASK_R2];
        mask = mask | {TAL_NCH{i_cfg[TAL_CFG_MASK_ALL]}};
    end

    // ------------------------------------------------------------
    // Status flags and read port
    // ------------------------------------------------------------
    always_comb begin
        trip_d = i_trip_wr ? i_trip : trip_q;
        hyst_d = i_hyst_wr ? i_hyst : hyst_q;   // see R12
        rd_p = i_rd_en && (i_rd_addr == TAL_ADDR_PRIMARY_STATUS);
        rd_s = i_rd_en && (i_rd_addr == TAL_ADDR_SECONDARY_STATUS);
        // A read clears sticky bits but a live cause sets them again
        open_d = open_q;
        hi_d = hi_q;
        lo_d = lo_q;
        if (rd_p) begin
            open_d[TAL_CH_R1] = 1'b0;
            hi_d[1:0] = 2'b00;                  // see R18
            lo_d[1:0] = 2'b00;
        end
        if (rd_s) begin
            open_d[TAL_CH_R2] = 1'b0;
            hi_d[TAL_CH_R2] = 1'b0;
            lo_d[TAL_CH_R2] = 1'b0;
        end
        // Open comparator checked only as a conversion starts (see R1)
        if (i_conv_start) begin
            open_d[TAL_CH_R1] = open_d[TAL_CH_R1] | i_open_cmp[TAL_CH_R1];
            open_d[TAL_CH_R2] = open_d[TAL_CH_R2] | i_open_cmp[TAL_CH_R2];
        end
        hi_d = hi_d | hi_now;      // see R17
        lo_d = lo_d | lo_now;
        rd_d = 8'h00;
        if (rd_p) begin
            rd_d[TAL_BIT_OPEN] = open_q[TAL_CH_R1];   // see R2
            rd_d[TAL_BIT_HIGH] = hi_q[TAL_CH_R1] | hi_q[TAL_CH_LOCAL];
            rd_d[TAL_BIT_LOW] = lo_q[TAL_CH_R1] | lo_q[TAL_CH_LOCAL];
            rd_d[TAL_BIT_TRIP] = |trip_now;
        end else if (rd_s) begin
            rd_d[TAL_BIT_OPEN] = open_q[TAL_CH_R2];   // see R3
            rd_d[TAL_BIT_HIGH] = hi_q[TAL_CH_R2];
            rd_d[TAL_BIT_LOW] = lo_q[TAL_CH_R2];
        end
    end

    // ------------------------------------------------------------
    // Alarm pin and fail-safe trip
    // ------------------------------------------------------------
    always_comb begin
        // Unmasked flag or open fault requests alarm (see R4, R6, R7)
        cause = |((hi_q | lo_q | open_q) & ~mask);
        st_d = st_q;
        unique case (st_q)
            TAL_AL_IDLE: if (cause) st_d = TAL_AL_ASSERT;
            TAL_AL_ASSERT: if (i_ara_served) st_d = TAL_AL_SERVED;
            // Release needs response, cleared status and cause (see R8)
            TAL_AL_SERVED: if (!cause) st_d = TAL_AL_IDLE;
            default: st_d = TAL_AL_IDLE;
        endcase
        if (i_pin_is_trip2) begin
            alarm_n_d = ~(|trip2_now);          // see R13
        end else begin
            alarm_n_d = (st_d == TAL_AL_IDLE);
        end
        fs_n_d = ~(|trip_now);                  // see R7, R9
    end

    // Register stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            // Zero-extend: the default limit is a positive temperature
            trip_q <= {TAL_NCH{10'(TAL_TRIP_DEFAULT)}}; // see R11
            hyst_q <= TAL_HYST_DEFAULT;         // see R12
            open_q <= '0;
            hi_q <= '0;
            lo_q <= '0;
            rd_q <= 8'h00;
            st_q <= TAL_AL_IDLE;
            alarm_n_q <= 1'b1;
            fs_n_q <= 1'b1;
        end else begin
            trip_q <= trip_d;
            hyst_q <= hyst_d;
            open_q <= open_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
            rd_q <= rd_d;
            st_q <= st_d;
            alarm_n_q <= alarm_n_d;
            fs_n_q <= fs_n_d;
        end
    end

    assign o_rd_data = rd_q;
    assign o_alarm_n = alarm_n_q;
    assign o_failsafe_trip_n = fs_n_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_OPEN_SET: assert property (@(posedge i_clk) disable iff (i_rst) // see R1
        i_conv_start && i_open_cmp[TAL_CH_R1] |=> open_q[TAL_CH_R1])
        else $error("open flag not set at conversion start");
    AST_OPEN_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // see R2
        !i_conv_start && !rd_p |=> $stable(open_q[TAL_CH_R1]))
        else $error("open flag changed outside conversion start");
    AST_FS_TRIP: assert property (@(posedge i_clk) disable iff (i_rst) // see R9
        |trip_now |=> !o_failsafe_trip_n)
        else $error("trip output not low");
    AST_FS_NOMASK: assert property (@(posedge i_clk) disable iff (i_rst) // see R7
        !(|trip_now) |=> o_failsafe_trip_n)
        else $error("trip output low with no trip");
    AST_ALARM_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // see R8
        st_q == TAL_AL_ASSERT && !i_ara_served && !i_pin_is_trip2
        |=> !o_alarm_n)
        else $error("alarm released before alert response");
    AST_ALARM_SET: assert property (@(posedge i_clk) disable iff (i_rst) // see R4
        st_q == TAL_AL_IDLE && cause && !i_pin_is_trip2 |=> !o_alarm_n)
        else $error("alarm not raised");
    AST_TRIP2: assert property (@(posedge i_clk) disable iff (i_rst) // see R13
        i_pin_is_trip2 && |trip2_now |=> !o_alarm_n)
        else $error("second trip not low");
    AST_STICKY: assert property (@(posedge i_clk) disable iff (i_rst) // see R18
        hi_q[TAL_CH_R2] && !rd_s |=> hi_q[TAL_CH_R2])
        else $error("high flag lost without read");
endmodule // tal_top

// *** tb_top.sv ***
// Testbench: trip, alarm, open-fault and offset checks of the block
`timescale 1ns/1ps
module tb_top;
    import tal_pkg::*;
    logic i_clk, i_rst, i_conv_start, i_trip_wr, i_hyst_wr;
    logic i_pin_is_trip2, i_rd_en, i_ara_served, o_alarm_n;
    logic o_failsafe_trip_n;
    logic [2:0] i_conv_done, i_open_cmp;
    logic [29:0] i_raw, i_offset, i_high, i_low, i_trip, o_temp;
    logic [7:0] i_hyst, i_cfg, i_consec, i_rd_addr, o_rd_data, rdat;
    int n_fail = 0;
    int n_compared = 0;
    tal_top dut_u (.i_clk(i_clk), .i_rst(i_rst),
        .i_conv_start(i_conv_start), .i_conv_done(i_conv_done),
        .i_open_cmp(i_open_cmp), .i_raw(i_raw), .i_offset(i_offset),
        .i_high(i_high), .i_low(i_low), .i_trip_wr(i_trip_wr),
        .i_trip(i_trip), .i_hyst_wr(i_hyst_wr), .i_hyst(i_hyst),
        .i_cfg(i_cfg), .i_consec(i_consec),
        .i_pin_is_trip2(i_pin_is_trip2), .i_rd_en(i_rd_en),
        .i_rd_addr(i_rd_addr), .i_ara_served(i_ara_served),
        .o_rd_data(o_rd_data), .o_alarm_n(o_alarm_n),
        .o_failsafe_trip_n(o_failsafe_trip_n), .o_temp(o_temp));
    tal_host_model host_u (.i_clk(i_clk), .i_rd_data(o_rd_data),
        .o_ara_served(i_ara_served), .o_rd_en(i_rd_en),
        .o_rd_addr(i_rd_addr));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [29:0] got, input logic [29:0] e);
        n_compared++;
        if (got !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, e);
        end
    endtask
    // One result on a channel; wait out the three-stage pin latency
    task automatic conv(input int c, input logic [9:0] v);
        @(posedge i_clk) i_raw[10*c +: 10] <= v;
        i_conv_done[c] <= 1'b1;
        @(posedge i_clk) i_conv_done <= 3'h0;
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    // Full service: alert response, status read, then the pin lets go
    task automatic service(input logic [7:0] a, input logic [7:0] e);
        host_u.ara();
        #1 chk(o_alarm_n, 1'b0);
        host_u.rd(a, rdat);
        chk(rdat, e);
        repeat (3) @(posedge i_clk);
        #1 chk(o_alarm_n, 1'b1);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_trip();
        @(posedge i_clk) i_cfg <= 8'h80;
        conv(2, 10'd85);
        chk(o_failsafe_trip_n, 1'b1);
        conv(2, 10'd86);
        chk(o_failsafe_trip_n, 1'b0);
        chk(o_alarm_n, 1'b1);
        conv(2, 10'd76);
        chk(o_failsafe_trip_n, 1'b0);
        conv(2, 10'd75);
        chk(o_failsafe_trip_n, 1'b1);
        @(posedge i_clk) i_hyst <= 8'h05;
        i_hyst_wr <= 1'b1;
        @(posedge i_clk) i_hyst_wr <= 1'b0;
        conv(2, 10'd86);
        conv(2, 10'd81);
        chk(o_failsafe_trip_n, 1'b0);
        // Trip status bit is live, so read it while the trip still stands
        host_u.rd(TAL_ADDR_PRIMARY_STATUS, rdat);
        chk(rdat, 8'h02);
        conv(2, 10'd80);
        chk(o_failsafe_trip_n, 1'b1);
        conv(2, 10'd40);
        host_u.rd(TAL_ADDR_SECONDARY_STATUS, rdat);
        chk(rdat, 8'h10);
        host_u.rd(TAL_ADDR_SECONDARY_STATUS, rdat);
        chk(rdat, 8'h00);
    endtask
    task automatic t_alarm();
        @(posedge i_clk) i_cfg <= 8'h00;
        conv(0, 10'd71);
        chk(o_alarm_n, 1'b0);
        conv(0, 10'd60);
        service(TAL_ADDR_PRIMARY_STATUS, 8'h10);
        @(posedge i_clk) i_low[9:0] <= 10'd10;
        conv(0, 10'd10);
        chk(o_alarm_n, 1'b0);
        conv(0, 10'd30);
        service(TAL_ADDR_PRIMARY_STATUS, 8'h08);
        // Raise the low limit to the stored value with no conversion
        @(posedge i_clk) i_low[9:0] <= 10'd30;
        repeat (4) @(posedge i_clk);
        #1 chk(o_alarm_n, 1'b0);
        @(posedge i_clk) i_low[9:0] <= 10'd10;
        service(TAL_ADDR_PRIMARY_STATUS, 8'h08);
    endtask
    // Open comparator raised first with no conversion start, then one
    task automatic t_open(input int c, input logic [7:0] a,
        input logic [9:0] old);
        @(posedge i_clk) i_open_cmp[c] <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1 chk(o_alarm_n, 1'b1);
        @(posedge i_clk) i_conv_start <= 1'b1;
        @(posedge i_clk) i_conv_start <= 1'b0;
        conv(c, 10'd99);
        chk(o_alarm_n, 1'b0);
        chk(o_temp[10*c +: 10], old);
        @(posedge i_clk) i_open_cmp[c] <= 1'b0;
        service(a, 8'h04);
    endtask
    task automatic t_misc();
        @(posedge i_clk) i_offset[9:0] <= 10'h3FD;
        conv(0, 10'd50);
        chk(o_temp[9:0], 10'd47);
        host_u.rd(8'h05, rdat);
        chk(rdat, 8'h00);
        @(posedge i_clk) i_pin_is_trip2 <= 1'b1;
        // Drop the offset so raw codes meet the high limit directly
        i_offset[9:0] <= 10'h000;
        i_cfg <= 8'h80;
        conv(0, 10'd71);
        chk(o_alarm_n, 1'b0);
        conv(0, 10'd66);
        chk(o_alarm_n, 1'b0);
        conv(0, 10'd65);
        chk(o_alarm_n, 1'b1);
    endtask
    // Clock and main sequence
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        i_rst = 1'b1;
        i_conv_start = 1'b0;
        i_conv_done = 3'h0;
        i_open_cmp = 3'h0;
        i_raw = 30'h0;
        i_offset = 30'h0;
        i_high = {3{10'h046}};
        i_low = {3{10'h3EC}};
        i_trip_wr = 1'b0;
        i_trip = {3{10'h055}};
        i_hyst_wr = 1'b0;
        i_hyst = 8'h00;
        i_cfg = 8'h00;
        i_consec = 8'h00;
        i_pin_is_trip2 = 1'b0;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        t_trip();
        t_alarm();
        t_open(1, TAL_ADDR_PRIMARY_STATUS, 10'd0);
        t_open(2, TAL_ADDR_SECONDARY_STATUS, 10'd40);
        t_misc();
        close_out();
    end
    // Whole run is a few hundred cycles; this limit cuts a hang short
    initial begin
        #100us;
        n_fail++;
        close_out();
    end
endmodule // tb_top
